// >>> design/seq_defs.svh
// constants for the input power-up sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
// clock and timing
`define CLK_HZ 50_000_000
`define REG_DELAY_MS 220
`define QUAL_TIME_MS 30
`define RETRY_TIME_S 2
`define INT_PULSE_CYC 32
// register byte offsets
`define OFS_CTRL 5'h00
`define OFS_ILIM 5'h04
`define OFS_VLIM 5'h08
`define OFS_STAT 5'h0c
// control bit positions
`define CTL_AUTO 0
`define CTL_FORCE 1
`define CTL_ABS 2
`define CTL_HIZ 3
`define CTL_CHG 4
// status bit positions
`define ST_IGOOD 0
`define ST_PGOOD 1
`define ST_HOSTP 2
`define ST_TYPE 3
`define ST_VFLAG 6
`define ST_IFLAG 7
`define ST_HIZ 8
`define ST_BSW 9
// reset values
`define CTRL_RST 5'h01
`define ILIM_RST 7'h0a
`define VLIM_RST 8'h2c
// limit codes, 50 mA steps
`define ILIM_500 7'h0a
`define ILIM_1500 7'h1e
`define ILIM_CAP 7'h04
// type codes
`define TYPE_HOST 3'h1
`define TYPE_ADPT 3'h2
// threshold algorithm, 100 mV steps
`define VLIM_OFS 8'h06
`define VLIM_MIN 8'h27
`endif

// >>> design/seq_pkg.sv
// types shared by the sequencer
package seq_pkg;
  // one-hot sequence states
  typedef enum logic [5:0] {
    ST_OFF = 6'b00_0001,
    ST_QUAL = 6'b00_0010,
    ST_RETRY = 6'b00_0100,
    ST_DETECT = 6'b00_1000,
    ST_VSET = 6'b01_0000,
    ST_RUN = 6'b10_0000
  } seq_state_t;
endpackage

// >>> design/input_power_up_sequencer.sv
// input power-up sequencer with wishbone registers
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "seq_defs.svh"

// Notes on behaviour
// - supply rise resets registers, then access allowed
// - battery-only overcurrent opens switch until attach
// - regulator, qualify, detect, voltage limit, converter
// - regulator needs uvlo, sleep margin, 220 ms
// - any condition false gives high impedance
// - qualification pass sets input good, pulses
// - failed qualification retried every 2 s
// - detect after input good, if auto enabled
// - detect done pulses, sets limit, power good
// - select high 500 mA host, low 1.5 A
// - auto off leaves limit and type unchanged
// - host rewrites limit; limit followed above 2.2 V
// - force request detects, then self-clears
// - absolute select makes voltage limit writable
// - otherwise voltage limit set by algorithm only
// - voltage limit established pulses interrupt
// - converter on; switch follows charge enable
// - below 2.2 V cap at 200 mA
// - loop active flags mirror limiting loops while converter on
module input_power_up_sequencer
  import seq_pkg::*;
#(
  parameter int CLK_HZ = `CLK_HZ,
  parameter int REG_DELAY_CYC = CLK_HZ / 1000 * `REG_DELAY_MS,
  parameter int QUAL_CYC = CLK_HZ / 1000 * `QUAL_TIME_MS,
  parameter int RETRY_CYC = CLK_HZ * `RETRY_TIME_S,
  parameter int PULSE_CYC = `INT_PULSE_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vbus_uvlo_ok_i,
  input wire logic bat_uvlo_ok_i,
  input wire logic vbus_above_sleep_i,
  input wire logic vbus_below_ov_i,
  input wire logic vbus_above_min_i,
  input wire logic port_select_i,
  input wire logic bat_ocp_i,
  input wire logic sys_above_2v2_i,
  input wire logic vlim_loop_i,
  input wire logic ilim_loop_i,
  input wire logic [7:0] vbus_code_i,
  output logic regulator_en_o,
  output logic test_load_o,
  output logic converter_en_o,
  output logic battery_switch_o,
  output logic high_impedance_state_o,
  output logic [6:0] ilim_eff_o,
  output logic [7:0] vlim_o,
  output logic int_n_o
);

  ////////////////////////////////////////////////////////////
  // parameter checks
  ////////////////////////////////////////////////////////////

  localparam int TW = 28;

  // counter must hold the longest wait
  if (REG_DELAY_CYC < 1 || QUAL_CYC < 1 || RETRY_CYC < 1
      || RETRY_CYC >= 2**(TW-1) || REG_DELAY_CYC >= 2**(TW-1)
      || QUAL_CYC >= 2**(TW-1))
  begin : g_bad_time
    $error("sequencer wait counts out of range");
  end
  if (PULSE_CYC < 1 || PULSE_CYC > 1000)
  begin : g_bad_pulse
    $error("interrupt pulse width out of range");
  end

  localparam logic [TW-1:0] REG_LAST = TW'(REG_DELAY_CYC - 1);
  localparam logic [TW-1:0] QUAL_LAST = TW'(QUAL_CYC - 1);
  localparam logic [TW-1:0] RETRY_LAST = TW'(RETRY_CYC - 1);
  localparam logic [10:0] P_HALF = 11'(PULSE_CYC);
  localparam logic [10:0] P_TOP = 11'(2 * PULSE_CYC - 1);
  // control reset value as a vector, so single bits can be picked
  localparam logic [4:0] CTRL_RV = `CTRL_RST;

  ////////////////////////////////////////////////////////////
  // declarations
  ////////////////////////////////////////////////////////////

  seq_state_t state_r; // sequence position
  logic [TW-1:0] cnt_r; // shared wait counter
  logic auto_en_r; // automatic detection on
  logic force_r; // forced detection request
  logic abs_sel_r; // host sets voltage limit
  logic hiz_req_r; // host high impedance request
  logic chg_en_r; // charging enabled
  logic [6:0] ilim_r; // input current limit setting
  logic [7:0] vlim_r; // input voltage limit
  logic [2:0] type_r; // input type code
  logic host_port_r; // host port flag
  logic igood_r; // input good flag
  logic pgood_r; // power good flag
  logic vflag_r; // voltage limit active
  logic iflag_r; // current limit active
  logic ocp_lat_r; // overcurrent latched off
  logic vbus_prev_r; // last input presence
  logic [1:0] pend_r; // queued interrupt events
  logic [10:0] pcnt_r; // pulse phase counter
  logic ack_r;
  logic [31:0] rdat_r;
  logic reg_en_r;
  logic load_r;
  logic conv_r;
  logic bsw_r;
  logic hiz_r;
  logic [6:0] ilim_eff_r;
  logic int_n_r;

  ////////////////////////////////////////////////////////////
  // combinational terms
  ////////////////////////////////////////////////////////////

  // either supply up keeps logic alive
  logic supply_ok;
  // register reset term
  logic por;
  // regulator enable conditions
  logic reg_cond;
  // source passes under load
  logic qual_ok;
  // end of a wait
  logic qual_end;
  // detection actually performed
  logic detect_do;
  // any bus request this cycle
  logic bus_req;
  // register writes
  logic wr_ctrl;
  logic wr_ilim;
  logic wr_vlim;
  // interrupt sources
  logic ev;
  logic pulse_go;
  logic [1:0] pend_nxt;
  logic [7:0] vlim_nxt;
  logic bsw_nxt;

  assign supply_ok = vbus_uvlo_ok_i | bat_uvlo_ok_i;
  assign por = rst_i | ~supply_ok;
  assign reg_cond = vbus_uvlo_ok_i & vbus_above_sleep_i & ~hiz_req_r;
  assign qual_ok = vbus_below_ov_i & vbus_above_min_i;
  assign qual_end = (state_r == ST_QUAL) && (cnt_r == QUAL_LAST);
  // auto pass in order, or a forced run while converting
  assign detect_do = ((state_r == ST_DETECT) && auto_en_r)
    || ((state_r == ST_RUN) && force_r);
  // no answer until a supply is up
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r & supply_ok;
  assign wr_ctrl = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OFS_CTRL);
  assign wr_ilim = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OFS_ILIM);
  assign wr_vlim = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OFS_VLIM);

  // threshold algorithm: measured input less a margin
  assign vlim_nxt = (vbus_code_i > (`VLIM_MIN + `VLIM_OFS))
    ? vbus_code_i - `VLIM_OFS : `VLIM_MIN;

  // events that earn an interrupt pulse
  assign ev = (qual_end && qual_ok && reg_cond)
    || (detect_do && reg_cond)
    || ((state_r == ST_VSET) && reg_cond);
  assign pulse_go = (pcnt_r == 11'h000) && (pend_r != 2'h0);

  // queue so back-to-back events never merge
  always_comb
  begin
    pend_nxt = pend_r;
    if (ev && !pulse_go && pend_r != 2'h3)
    begin
      pend_nxt = pend_r + 2'h1;
    end
    else if (!ev && pulse_go)
    begin
      pend_nxt = pend_r - 2'h1;
    end
  end

  // battery switch: opens at once on overcurrent while the input is below uvlo
  always_comb
  begin
    if (ocp_lat_r || (bat_ocp_i && !vbus_uvlo_ok_i))
    begin
      bsw_nxt = 1'b0;
    end
    else if (state_r == ST_RUN)
    begin
      bsw_nxt = chg_en_r;
    end
    else
    begin
      // battery carries the system meanwhile
      bsw_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // sequence state machine
  ////////////////////////////////////////////////////////////

  // one step per stage, strictly in order
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      state_r <= ST_OFF;
      cnt_r <= '0;
    end
    else if (!reg_cond)
    begin
      // any lost condition restarts the delay
      state_r <= ST_OFF;
      cnt_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_OFF:
        begin
          if (cnt_r == REG_LAST)
          begin
            state_r <= ST_QUAL;
            cnt_r <= '0;
          end
          else
          begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_QUAL:
        begin
          // load applied for the whole window
          if (qual_end)
          begin
            state_r <= qual_ok ? ST_DETECT : ST_RETRY;
            cnt_r <= '0;
          end
          else
          begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_RETRY:
        begin
          if (cnt_r == RETRY_LAST)
          begin
            state_r <= ST_QUAL;
            cnt_r <= '0;
          end
          else
          begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_DETECT:
        begin
          // skipped in one cycle when auto is off
          state_r <= ST_VSET;
        end
        ST_VSET:
        begin
          state_r <= ST_RUN;
        end
        ST_RUN:
        begin
          // forced detection runs without leaving
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // control register
  ////////////////////////////////////////////////////////////

  // host-owned bits
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      {chg_en_r, hiz_req_r, abs_sel_r, auto_en_r} <=
        {CTRL_RV[`CTL_CHG], CTRL_RV[`CTL_HIZ],
         CTRL_RV[`CTL_ABS], CTRL_RV[`CTL_AUTO]};
    end
    else if (wr_ctrl)
    begin
      auto_en_r <= wb_dat_i[`CTL_AUTO];
      abs_sel_r <= wb_dat_i[`CTL_ABS];
      hiz_req_r <= wb_dat_i[`CTL_HIZ];
      chg_en_r <= wb_dat_i[`CTL_CHG];
    end
  end

  // force bit: a host write beats the self-clear
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      force_r <= CTRL_RV[`CTL_FORCE];
    end
    else if (wr_ctrl)
    begin
      force_r <= wb_dat_i[`CTL_FORCE];
    end
    else if (detect_do && force_r)
    begin
      force_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // detection results
  ////////////////////////////////////////////////////////////

  // current limit: host write wins a tie
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      ilim_r <= `ILIM_RST;
    end
    else if (wr_ilim)
    begin
      ilim_r <= wb_dat_i[6:0];
    end
    else if (detect_do)
    begin
      ilim_r <= port_select_i ? `ILIM_500 : `ILIM_1500;
    end
  end

  // type code and host port flag
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      type_r <= 3'h0;
      host_port_r <= 1'b0;
    end
    else if (detect_do)
    begin
      type_r <= port_select_i ? `TYPE_HOST : `TYPE_ADPT;
      host_port_r <= port_select_i;
    end
  end

  // input good and power good follow the sequence
  always_ff @(posedge clk_i)
  begin
    if (por || state_r == ST_OFF)
    begin
      igood_r <= 1'b0;
      pgood_r <= 1'b0;
    end
    else
    begin
      if (qual_end && qual_ok)
      begin
        igood_r <= 1'b1;
      end
      if (detect_do)
      begin
        pgood_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // input voltage limit
  ////////////////////////////////////////////////////////////

  // writable only in absolute mode
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      vlim_r <= `VLIM_RST;
    end
    else if (!abs_sel_r && state_r == ST_VSET)
    begin
      vlim_r <= vlim_nxt;
    end
    else if (abs_sel_r && wr_vlim)
    begin
      vlim_r <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // battery switch overcurrent latch
  ////////////////////////////////////////////////////////////

  // held off until a fresh input attach; set wins
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      ocp_lat_r <= 1'b0;
      vbus_prev_r <= 1'b0;
    end
    else
    begin
      vbus_prev_r <= vbus_uvlo_ok_i;
      if (bat_ocp_i && !vbus_uvlo_ok_i)
      begin
        ocp_lat_r <= 1'b1;
      end
      else if (vbus_uvlo_ok_i && !vbus_prev_r)
      begin
        ocp_lat_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // interrupt pulse generator
  ////////////////////////////////////////////////////////////

  // low for PULSE_CYC, then high as long before next
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      pend_r <= 2'h0;
      pcnt_r <= 11'h000;
      int_n_r <= 1'b1;
    end
    else
    begin
      pend_r <= pend_nxt;
      if (pulse_go)
      begin
        pcnt_r <= P_TOP;
        int_n_r <= 1'b0;
      end
      else if (pcnt_r != 11'h000)
      begin
        pcnt_r <= pcnt_r - 11'h001;
        if (pcnt_r == P_HALF)
        begin
          int_n_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // power path outputs
  ////////////////////////////////////////////////////////////

  // enables decoded from the state, registered
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      reg_en_r <= 1'b0;
      load_r <= 1'b0;
      conv_r <= 1'b0;
      hiz_r <= 1'b1;
      bsw_r <= 1'b0;
    end
    else
    begin
      reg_en_r <= reg_cond && state_r != ST_OFF;
      load_r <= reg_cond && state_r == ST_QUAL;
      conv_r <= reg_cond && state_r == ST_RUN;
      hiz_r <= !reg_cond || state_r == ST_OFF;
      bsw_r <= bsw_nxt;
    end
  end

  // soft-start cap and loop flags
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      // rail is down while in reset, so the soft-start cap applies
      ilim_eff_r <= `ILIM_CAP;
      vflag_r <= 1'b0;
      iflag_r <= 1'b0;
    end
    else
    begin
      // the register always governs, capped low
      if (!sys_above_2v2_i && ilim_r > `ILIM_CAP)
      begin
        ilim_eff_r <= `ILIM_CAP;
      end
      else
      begin
        ilim_eff_r <= ilim_r;
      end
      vflag_r <= vlim_loop_i && conv_r;
      iflag_r <= ilim_loop_i && conv_r;
    end
  end

  ////////////////////////////////////////////////////////////
  // wishbone slave
  ////////////////////////////////////////////////////////////

  // one-cycle ack, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (por)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_req;
      rdat_r <= 32'h0000_0000;
      if (bus_req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          `OFS_CTRL: rdat_r[4:0] <= {chg_en_r, hiz_req_r,
            abs_sel_r, force_r, auto_en_r};
          `OFS_ILIM: rdat_r[6:0] <= ilim_r;
          `OFS_VLIM: rdat_r[7:0] <= vlim_r;
          `OFS_STAT: rdat_r[9:0] <= {bsw_r, hiz_r, iflag_r,
            vflag_r, type_r, host_port_r, pgood_r, igood_r};
          default: rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign regulator_en_o = reg_en_r;
  assign test_load_o = load_r;
  assign converter_en_o = conv_r;
  assign battery_switch_o = bsw_r;
  assign high_impedance_state_o = hiz_r;
  assign ilim_eff_o = ilim_eff_r;
  assign vlim_o = vlim_r;
  assign int_n_o = int_n_r;

endmodule // input_power_up_sequencer

// >>> verif/seq_properties.sv
// port-level assertions for the input power-up sequencer
`timescale 1ns/1ps
`include "seq_defs.svh"
module seq_checker #(
  parameter int PULSE_CYC = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic vbus_uvlo_ok_i,
  input wire logic bat_uvlo_ok_i,
  input wire logic bat_ocp_i,
  input wire logic sys_above_2v2_i,
  input wire logic regulator_en_o,
  input wire logic test_load_o,
  input wire logic converter_en_o,
  input wire logic battery_switch_o,
  input wire logic high_impedance_state_o,
  input wire logic [6:0] ilim_eff_o,
  input wire logic int_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int low_r; // cycles the interrupt has been low
  int high_r; // cycles it has been high, saturating
  ////////////////////////////////////////////////////////////
  // low-time counter of the interrupt pulse
  always_ff @(posedge clk_i)
    low_r <= (rst_i || int_n_o) ? 0 : low_r + 1;
  // high-time counter, saturates so it never wraps
  always_ff @(posedge clk_i)
    high_r <= rst_i ? 1000 : (!int_n_o ? 0 : (high_r < 1000 ? high_r + 1 : high_r));
  ////////////////////////////////////////////////////////////
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
    (vbus_uvlo_ok_i || bat_uvlo_ok_i) |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_hiz_off: assert property (!vbus_uvlo_ok_i |-> ##2 !regulator_en_o &&
    high_impedance_state_o)
    else $error("regulator on without input");
  a_load_in_reg: assert property (test_load_o |-> regulator_en_o && !converter_en_o)
    else $error("test load out of order");
  a_conv_order: assert property ($rose(converter_en_o) |-> regulator_en_o &&
    !high_impedance_state_o)
    else $error("converter started early");
  a_ocp_open: assert property (bat_ocp_i && !vbus_uvlo_ok_i && bat_uvlo_ok_i
    |=> !battery_switch_o)
    else $error("switch not opened on overcurrent");
  a_ocp_hold: assert property (bat_ocp_i && !vbus_uvlo_ok_i && bat_uvlo_ok_i
    ##1 !vbus_uvlo_ok_i [*3] |-> !battery_switch_o)
    else $error("switch reclosed without input");
  a_cap_low: assert property (!sys_above_2v2_i |=> ilim_eff_o <= `ILIM_CAP)
    else $error("limit above cap on low rail");
  a_int_width: assert property ($rose(int_n_o) |-> low_r == PULSE_CYC)
    else $error("interrupt pulse width wrong");
  a_int_gap: assert property ($fell(int_n_o) |-> high_r >= PULSE_CYC)
    else $error("interrupt pulses merged");
endmodule // seq_checker

bind input_power_up_sequencer seq_checker #(.PULSE_CYC(PULSE_CYC)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vbus_uvlo_ok_i(vbus_uvlo_ok_i),
  .bat_uvlo_ok_i(bat_uvlo_ok_i), .bat_ocp_i(bat_ocp_i), .sys_above_2v2_i(sys_above_2v2_i),
  .regulator_en_o(regulator_en_o), .test_load_o(test_load_o),
  .converter_en_o(converter_en_o), .battery_switch_o(battery_switch_o),
  .high_impedance_state_o(high_impedance_state_o), .ilim_eff_o(ilim_eff_o),
  .int_n_o(int_n_o));

// >>> verif/analog_env.sv
// behavioural model of the input source and system rail comparators
`timescale 1ns/1ps
module analog_env (
  input wire logic clk_i,
  input wire logic plug_i,
  input wire logic poor_i,
  input wire logic load_i,
  input wire logic conv_i,
  input wire logic sys_drop_i,
  output logic vbus_uvlo_ok_o,
  output logic vbus_above_sleep_o,
  output logic vbus_below_ov_o,
  output logic vbus_above_min_o,
  output logic sys_above_2v2_o
);
  logic [3:0] ramp_r = 4'h0; // system rail ramp after converter start
  logic tog_r = 1'b0; // changing pattern for an unloaded comparator
  ////////////////////////////////////////////////////////////
  // rail climbs only while the converter runs
  always_ff @(posedge clk_i)
    ramp_r <= !conv_i ? 4'h0 : (ramp_r == 4'hf ? ramp_r : ramp_r + 4'h1);
  // minimum comparator is meaningless without the test load
  always_ff @(posedge clk_i)
    tog_r <= ~tog_r;
  assign vbus_uvlo_ok_o = plug_i;
  assign vbus_above_sleep_o = plug_i;
  assign vbus_below_ov_o = 1'b1;
  assign vbus_above_min_o = load_i ? (plug_i & ~poor_i) : tog_r;
  // overload pulls the rail back below the soft-start level
  assign sys_above_2v2_o = (ramp_r > 4'h5) & ~sys_drop_i;
endmodule // analog_env

// >>> verif/tb.sv
// self-checking bench for the input power-up sequencer
`timescale 1ns/1ps
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
`define WAITON(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge clk_i); n++; end \
  `CHK("wait", 1'b1, n < 3000) end
module tb;
  localparam int RD = 20;
  localparam int RC = 30;
  localparam int PC = 4;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [4:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, rd, rdat;
  logic plug = 0, poor = 0, sys_drop = 0, bat_ok = 1, psel = 0, ocp = 0;
  logic vloop = 0, iloop = 0;
  logic [7:0] code = 8'h50, vlim;
  logic [6:0] v, ilim_eff;
  logic ack, reg_en, load, conv, bsw, high_impedance_state, int_n, v_uv, v_sl, v_ov, v_min, sys_ok;
  int n, pulses = 0, error_cnt = 0, total_checks = 0;
  ////////////////////////////////////////////////////////////
  always #10 clk_i = ~clk_i;
  // count interrupt pulses
  always @(negedge int_n)
    pulses++;
  input_power_up_sequencer #(.REG_DELAY_CYC(RD), .QUAL_CYC(8), .RETRY_CYC(RC),
    .PULSE_CYC(PC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .vbus_uvlo_ok_i(v_uv), .bat_uvlo_ok_i(bat_ok),
    .vbus_above_sleep_i(v_sl), .vbus_below_ov_i(v_ov), .vbus_above_min_i(v_min),
    .port_select_i(psel), .bat_ocp_i(ocp), .sys_above_2v2_i(sys_ok),
    .vlim_loop_i(vloop), .ilim_loop_i(iloop), .vbus_code_i(code), .regulator_en_o(reg_en),
    .test_load_o(load), .converter_en_o(conv), .battery_switch_o(bsw),
    .high_impedance_state_o(high_impedance_state), .ilim_eff_o(ilim_eff), .vlim_o(vlim), .int_n_o(int_n));
  analog_env env (.clk_i(clk_i), .plug_i(plug), .poor_i(poor), .load_i(load),
    .conv_i(conv), .sys_drop_i(sys_drop), .vbus_uvlo_ok_o(v_uv), .vbus_above_sleep_o(v_sl),
    .vbus_below_ov_o(v_ov), .vbus_above_min_o(v_min), .sys_above_2v2_o(sys_ok));
  ////////////////////////////////////////////////////////////
  // classic single cycle; the request stands until ack is sampled
  task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    `CHK("ack cycles", 2, k)
  endtask
  // threshold algorithm: measured input less offset, floored
  function automatic logic [7:0] vexp(input logic [7:0] c);
    return (c < 8'h2d) ? 8'h27 : c - 8'h06;
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, far beyond the expected few hundred cycles
  initial
  begin
    #(20 * 30000);
    error_cnt++;
    conclude();
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(96428));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(5'h00, 0, 0); `CHK("ctrl", 32'h0000_0001, rd)
    wb(5'h04, 0, 0); `CHK("ilim", 32'h0000_000a, rd)
    wb(5'h08, 0, 0); `CHK("vlim", 32'h0000_002c, rd)
    wb(5'h10, 0, 0); `CHK("unmapped", 32'h0000_0000, rd)
    `CHK("hiz", 1'b1, high_impedance_state)
    `CHK("reg off", 1'b0, reg_en)
    ocp <= 1'b1;
    repeat (2) @(posedge clk_i);
    ocp <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("bsw ocp", 1'b0, bsw)
    // host port attach with random measured input
    code <= 8'($urandom_range(32, 143));
    psel <= 1'b1;
    plug <= 1'b1;
    pulses = 0;
    `WAITON(reg_en === 1'b1)
    `CHK("delay", 1'b1, n >= RD && n <= RD + 4)
    `CHK("bsw attach", 1'b1, bsw)
    `WAITON(conv === 1'b1)
    repeat (8 * PC) @(posedge clk_i);
    `CHK("pulses", 3, pulses)
    wb(5'h0c, 0, 0); `CHK("stat", 10'h00f, rd[9:0])
    wb(5'h04, 0, 0); `CHK("ilim host", 32'h0000_000a, rd)
    wb(5'h08, 0, 0); `CHK("vlim alg", vexp(code), rd[7:0])
    wb(5'h08, 1, 32'h0000_0055);
    wb(5'h08, 0, 0); `CHK("vlim ro", vexp(code), rd[7:0])
    wb(5'h00, 1, 32'h0000_0005);
    wb(5'h08, 1, 32'h0000_0055);
    wb(5'h08, 0, 0); `CHK("vlim rw", 32'h0000_0055, rd)
    `CHK("vlim pin", 8'h55, vlim)
    v = 7'($urandom_range(1, 127));
    wb(5'h04, 1, {25'h0, v});
    repeat (2) @(posedge clk_i);
    `CHK("ilim eff", v, ilim_eff)
    sys_drop <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("ilim cap", (v < 7'h04) ? v : 7'h04, ilim_eff)
    sys_drop <= 1'b0;
    vloop <= 1'b1;
    iloop <= 1'b1;
    repeat (3) @(posedge clk_i);
    wb(5'h0c, 0, 0); `CHK("loop flags", 2'b11, rd[7:6])
    vloop <= 1'b0;
    iloop <= 1'b0;
    // forced detection on an adapter
    psel <= 1'b0;
    pulses = 0;
    wb(5'h00, 1, 32'h0000_0007);
    repeat (10) @(posedge clk_i);
    wb(5'h00, 0, 0); `CHK("force clr", 32'h0000_0005, rd)
    wb(5'h04, 0, 0); `CHK("ilim adpt", 32'h0000_001e, rd)
    wb(5'h0c, 0, 0); `CHK("type adpt", 4'h4, rd[5:2])
    `CHK("force int", 1, pulses)
    wb(5'h00, 1, 32'h0000_0015);
    repeat (3) @(posedge clk_i);
    `CHK("bsw chg", 1'b1, bsw)
    // host asks for high impedance
    wb(5'h00, 1, 32'h0000_001d);
    `WAITON(high_impedance_state === 1'b1)
    repeat (3) @(posedge clk_i);
    `CHK("hiz reg", 1'b0, reg_en)
    // restart with detection disabled
    psel <= 1'b1;
    wb(5'h04, 1, 32'h0000_0011);
    pulses = 0;
    wb(5'h00, 1, 32'h0000_0000);
    `WAITON(conv === 1'b1)
    repeat (8 * PC) @(posedge clk_i);
    `CHK("pulses auto off", 2, pulses)
    wb(5'h04, 0, 0); `CHK("ilim kept", 32'h0000_0011, rd)
    wb(5'h0c, 0, 0); `CHK("type kept", 4'h4, rd[5:2])
    // poor source is retried
    plug <= 1'b0;
    poor <= 1'b1;
    repeat (5) @(posedge clk_i);
    plug <= 1'b1;
    `WAITON(load === 1'b1)
    `WAITON(load === 1'b0)
    `WAITON(load === 1'b1)
    `CHK("retry gap", 1'b1, n >= RC - 1 && n <= RC + 3)
    `CHK("no conv", 1'b0, conv)
    poor <= 1'b0;
    `WAITON(conv === 1'b1)
    // let queued pulses finish, a cut pulse is not a width fault
    repeat (8 * PC) @(posedge clk_i);
    // both supplies gone resets the registers
    plug <= 1'b0;
    bat_ok <= 1'b0;
    repeat (4) @(posedge clk_i);
    bat_ok <= 1'b1;
    repeat (2) @(posedge clk_i);
    wb(5'h04, 0, 0); `CHK("ilim por", 32'h0000_000a, rd)
    wb(5'h00, 0, 0); `CHK("ctrl por", 32'h0000_0001, rd)
    conclude();
  end
endmodule // tb
